// *** verilog/self_test_pkg.sv ***
// shared constants of the self-test error collector
package self_test_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int POLL_WAIT_NS  = 1000;
  localparam int POLL_WAIT_CYC = (POLL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STUCK_NS      = 10000;
  localparam int STUCK_CYC     = (STUCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 12;

  // ==========================================================
  // error words
  localparam int FATAL_W    = 8;
  localparam int NONFATAL_W = 24;
  localparam int CMD_W      = 32;
  localparam logic [FATAL_W-1:0]    FATAL_MASK    = 8'h37;
  localparam logic [NONFATAL_W-1:0] NONFATAL_MASK = 24'h7fffff;
  localparam logic [CMD_W-1:0]      CMD_MASK      = 32'h01ffffff;
  localparam int DIGIT_W = 3;

  // ==========================================================
  // display codes and messages
  localparam logic [7:0] ERR_NONE     = 8'h00;
  localparam logic [7:0] ERR_NONFATAL = 8'h1a;
  localparam logic [7:0] ERR_CMD      = 8'h1b;
  localparam logic [7:0] ERR_FATAL    = 8'h50;
  localparam int MSG_W = 3;
  localparam logic [MSG_W-1:0] MSG_NONE      = 3'h0;
  localparam logic [MSG_W-1:0] MSG_PON_FAIL  = 3'h1;
  localparam logic [MSG_W-1:0] MSG_TEST_FAIL = 3'h2;
  localparam logic [MSG_W-1:0] MSG_TEST_OK   = 3'h3;
  localparam logic [MSG_W-1:0] MSG_READY     = 3'h4;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_A    = 8'h41;

  // ==========================================================
  // check phases and last-word kinds
  localparam logic [1:0] PH_NONE     = 2'h0;
  localparam logic [1:0] PH_FATAL    = 2'h1;
  localparam logic [1:0] PH_NONFATAL = 2'h2;
  localparam logic [1:0] PH_CMD      = 2'h3;

  // ==========================================================
  // slot answers
  localparam int MODEL_W = 8;
  localparam logic [1:0] SLOT_EMPTY   = 2'h0;
  localparam logic [1:0] SLOT_PARTIAL = 2'h1;
  localparam logic [1:0] SLOT_FULL    = 2'h2;

  // ==========================================================
  // register map
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] REG_CTRL      = 8'h00;
  localparam logic [REG_AW-1:0] REG_STATUS    = 8'h04;
  localparam logic [REG_AW-1:0] REG_FATAL     = 8'h08;
  localparam logic [REG_AW-1:0] REG_NONFATAL  = 8'h0c;
  localparam logic [REG_AW-1:0] REG_CMDTEST   = 8'h10;
  localparam logic [REG_AW-1:0] REG_ERROR_STRING_QUERY    = 8'h14;
  localparam logic [REG_AW-1:0] REG_HEXSEL    = 8'h18;
  localparam logic [REG_AW-1:0] REG_HEXCHAR   = 8'h1c;
  localparam logic [REG_AW-1:0] REG_SLOT_BASE = 8'h20;
  localparam int CTRL_START  = 0;
  localparam int STAT_READY  = 8;
  localparam int STAT_LOCKED = 9;
  localparam int STAT_PEND   = 10;
  localparam int STAT_STUCK  = 11;
  localparam int ERROR_STRING_QUERY_MSG  = 8;
  localparam int ERROR_STRING_QUERY_KIND = 12;
  localparam int SLOT_RESP   = 8;
endpackage

// *** verilog/hex_digit_render.sv ***
// one hexadecimal digit of an error word as an ascii character
`timescale 1ns/1ps
`default_nettype none
module hex_digit_render (
  // word and digit position, 0 is the rightmost
  input  wire logic [self_test_pkg::CMD_W-1:0]   word,
  input  wire logic [self_test_pkg::DIGIT_W-1:0] digit,
  // rendered character
  output logic      [7:0]                        ascii
);
  import self_test_pkg::*;

  function automatic logic [7:0] hex_ascii(input logic [3:0] nib);
    logic [7:0] wide;
    wide = {4'h0, nib};
    if (nib < 4'ha) begin
      hex_ascii = ASCII_ZERO + wide;
    end else begin
      hex_ascii = ASCII_A + wide - 8'h0a;
    end
  endfunction

  // digit 0 carries data bits 3..0
  wire logic [3:0] nibble = word[{digit, 2'b00} +: 4];
  assign ascii = hex_ascii(nibble);
endmodule
`default_nettype wire

// *** verilog/self_test_error_collector.sv ***
// self-test sequencer, error word collector and backplane slot enumerator
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - reduced fatal word bits 0,1,2,4,5; 3,6,7 zero
// - non-fatal test only after clean fatal test
// - non-fatal failures recorded, test keeps running
// - non-fatal word is 24 bits, bit0 rightmost
// - failure bits accumulate and stay set
// - non-fatal bits 0-7 latch, clock, pacer faults
// - non-fatal bits 8-16 crystal, backplane, options
// - non-fatal bits 17-22 panel faults, 23 unused
// - non-fatal failure shows error 26, reaches ready
// - command test accepted any time, state untouched
// - command test lights all segments, tone, pass
// - command failure beeps, error 27, 32-bit word
// - command bits 0-8 memory and acknowledge faults
// - command bits 9-18 clock, backplane, options
// - command bits 19-24 panel faults, rest unused
// - each hex digit four bits, bit0 rightmost
// - controller waits on shared transfer acknowledge
// - stuck acknowledge after wake-up stops servicing
// - reset polls every slot into a table
// - later insertions ignored until next reset
// - fatal failure beeps, error 80, locks up
// - reduced fatal word offered to instrument bus
module self_test_error_collector #(
  parameter int NUM_SLOTS = 8,
  parameter int SLOT_AW   = 3
) (
  // clock and reset
  input  wire logic                               sys_clk,
  input  wire logic                               reset,
  // register port
  input  wire logic [self_test_pkg::REG_AW-1:0]   reg_addr,
  input  wire logic [31:0]                        reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output logic      [31:0]                        reg_rdata,
  // check engine
  output logic      [1:0]                         check_phase,
  input  wire logic [31:0]                        check_fail,
  input  wire logic                               check_done,
  // backplane
  output logic                                    slot_poll,
  output logic      [SLOT_AW-1:0]                 slot_sel,
  input  wire logic                               transfer_acknowledge_n,
  input  wire logic [1:0]                         slot_resp,
  input  wire logic [self_test_pkg::MODEL_W-1:0]  slot_model,
  // front panel
  output logic      [7:0]                         error_code,
  output logic      [self_test_pkg::MSG_W-1:0]    message,
  output logic                                    error_annunc,
  output logic                                    beep,
  output logic                                    tone,
  output logic                                    all_segments,
  output logic                                    ready,
  output logic                                    locked,
  output logic                                    service_en,
  // instrument bus
  output logic      [self_test_pkg::FATAL_W-1:0]  fatal_word
);
  import self_test_pkg::*;

  // ==========================================================
  // state
  typedef enum logic [7:0] {
    ST_ENUM      = 8'h01,
    ST_ENUM_WAIT = 8'h02,
    ST_ENUM_REL  = 8'h04,
    ST_FATAL     = 8'h08,
    ST_NONFATAL  = 8'h10,
    ST_READY     = 8'h20,
    ST_CMD       = 8'h40,
    ST_LOCK      = 8'h80
  } state_e;

  state_e                  state_q, state_d;
  logic [FATAL_W-1:0]      fatal_q, fatal_d;
  logic [NONFATAL_W-1:0]   nf_q, nf_d;
  logic [CMD_W-1:0]        cmd_q, cmd_d;
  logic [CNT_W-1:0]        timer_q, stuck_q, stuck_d;
  logic [SLOT_AW-1:0]      slot_idx_q;
  logic [SLOT_RESP+1:0]    slot_tab_q [NUM_SLOTS];
  logic                    cmd_pend_q, cmd_pend_d;
  logic [1:0]              kind_q;
  logic [DIGIT_W-1:0]      hex_sel_q;
  logic [31:0]             rdata_q, status_w;
  logic [1:0]              phase_q;
  logic                    poll_q, beep_q, tone_q, seg_q, ready_q, locked_q, serv_q, annunc_q;
  logic [7:0]              code_q;
  logic [MSG_W-1:0]        msg_q;

  // ==========================================================
  // decode of events
  wire logic [FATAL_W-1:0]    fatal_fail = check_fail[FATAL_W-1:0] & FATAL_MASK;
  wire logic [NONFATAL_W-1:0] nf_fail    = check_fail[NONFATAL_W-1:0] & NONFATAL_MASK;
  wire logic [CMD_W-1:0]      cmd_fail   = check_fail & CMD_MASK;
  wire logic [NONFATAL_W-1:0] nf_acc     = nf_q | nf_fail;
  wire logic [CMD_W-1:0]      cmd_acc    = cmd_q | cmd_fail;
  wire logic fatal_bad  = (state_q == ST_FATAL) && (|fatal_fail);
  wire logic fatal_ok   = (state_q == ST_FATAL) && check_done && !fatal_bad;
  wire logic nf_end     = (state_q == ST_NONFATAL) && check_done;
  wire logic nf_bad     = nf_end && (|nf_acc);
  wire logic cmd_end    = (state_q == ST_CMD) && check_done;
  wire logic cmd_bad    = cmd_end && (|cmd_acc);
  wire logic ack_low    = !transfer_acknowledge_n;
  wire logic poll_hit   = (state_q == ST_ENUM_WAIT) && ack_low;
  wire logic poll_miss  = (state_q == ST_ENUM_WAIT) && !ack_low && (timer_q == '0);
  wire logic last_slot  = slot_idx_q == SLOT_AW'(NUM_SLOTS - 1);
  wire logic awake      = (state_q == ST_READY) || (state_q == ST_CMD);
  wire logic stuck_now  = stuck_d == CNT_W'(STUCK_CYC);
  wire logic cmd_go     = (state_q == ST_READY) && cmd_pend_q && !stuck_now;
  wire logic ctrl_wr    = reg_wr && (reg_addr == REG_CTRL);
  wire logic hexsel_wr  = reg_wr && (reg_addr == REG_HEXSEL);

  // ==========================================================
  // sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      // a line held low before the poll stalls the scan here
      ST_ENUM:      if (!ack_low) state_d = ST_ENUM_WAIT;
      ST_ENUM_WAIT: begin
        if (poll_hit) begin
          state_d = ST_ENUM_REL;
        end else if (poll_miss) begin
          state_d = last_slot ? ST_FATAL : ST_ENUM;
        end
      end
      ST_ENUM_REL:  if (!ack_low) state_d = last_slot ? ST_FATAL : ST_ENUM;
      ST_FATAL: begin
        if (fatal_bad) begin
          state_d = ST_LOCK;
        end else if (fatal_ok) begin
          state_d = ST_NONFATAL;
        end
      end
      ST_NONFATAL:  if (nf_end) state_d = ST_READY;
      ST_READY:     if (cmd_go) state_d = ST_CMD;
      ST_CMD:       if (cmd_end) state_d = ST_READY;
      ST_LOCK:      state_d = ST_LOCK;
      default:      state_d = ST_ENUM;
    endcase
  end

  wire logic enter_fatal = (state_d == ST_FATAL) && (state_q != ST_FATAL);
  wire logic enter_nf    = (state_d == ST_NONFATAL) && (state_q != ST_NONFATAL);
  wire logic enter_cmd   = (state_d == ST_CMD) && (state_q != ST_CMD);

  // words start clean and only gain bits while their test runs
  assign fatal_d = enter_fatal ? '0 : (state_q == ST_FATAL) ? (fatal_q | fatal_fail) : fatal_q;
  assign nf_d    = enter_nf ? '0 : (state_q == ST_NONFATAL) ? nf_acc : nf_q;
  assign cmd_d   = enter_cmd ? '0 : (state_q == ST_CMD) ? cmd_acc : cmd_q;
  // a request may come at any time and waits for ready
  assign cmd_pend_d = (ctrl_wr && reg_wdata[CTRL_START]) || (cmd_pend_q && !cmd_go);
  // only a line low while awake counts as stuck
  assign stuck_d = !(awake && ack_low) ? '0 :
                   (stuck_q == CNT_W'(STUCK_CYC)) ? stuck_q : stuck_q + 1'b1;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q    <= ST_ENUM;
      fatal_q    <= '0;
      nf_q       <= '0;
      cmd_q      <= '0;
      cmd_pend_q <= 1'b0;
      stuck_q    <= '0;
    end else begin
      state_q    <= state_d;
      fatal_q    <= fatal_d;
      nf_q       <= nf_d;
      cmd_q      <= cmd_d;
      cmd_pend_q <= cmd_pend_d;
      stuck_q    <= stuck_d;
    end
  end

  // ==========================================================
  // slot enumeration, only after reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      slot_idx_q <= '0;
      timer_q    <= '0;
    end else begin
      if (state_d == ST_ENUM_WAIT && state_q != ST_ENUM_WAIT) begin
        timer_q <= CNT_W'(POLL_WAIT_CYC);
      end else if (state_q == ST_ENUM_WAIT && timer_q != '0) begin
        timer_q <= timer_q - 1'b1;
      end
      if ((poll_miss || (state_q == ST_ENUM_REL && !ack_low)) && !last_slot) begin
        slot_idx_q <= slot_idx_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_tab_q[i] <= '0;
      end
    end else if (poll_hit) begin
      slot_tab_q[slot_idx_q] <= {slot_resp, slot_model};
    end else if (poll_miss) begin
      slot_tab_q[slot_idx_q] <= {SLOT_EMPTY, {MODEL_W{1'b0}}};
    end
  end

  // ==========================================================
  // panel outputs
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      phase_q  <= PH_NONE;
      poll_q   <= 1'b0;
      beep_q   <= 1'b0;
      tone_q   <= 1'b0;
      seg_q    <= 1'b0;
      ready_q  <= 1'b0;
      locked_q <= 1'b0;
      serv_q   <= 1'b0;
    end else begin
      phase_q  <= (state_d == ST_FATAL) ? PH_FATAL : (state_d == ST_NONFATAL) ? PH_NONFATAL :
                  (state_d == ST_CMD) ? PH_CMD : PH_NONE;
      poll_q   <= state_d == ST_ENUM_WAIT;
      beep_q   <= fatal_bad || cmd_bad;
      tone_q   <= state_d == ST_CMD;
      seg_q    <= state_d == ST_CMD;
      ready_q  <= state_d == ST_READY;
      locked_q <= state_d == ST_LOCK;
      serv_q   <= (state_d == ST_READY) && !stuck_now;
    end
  end

  // code and message stay put while stuck, the display keeps its state
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      code_q   <= ERR_NONE;
      msg_q    <= MSG_NONE;
      annunc_q <= 1'b0;
      kind_q   <= PH_NONE;
    end else if (fatal_bad) begin
      code_q   <= ERR_FATAL;
      msg_q    <= MSG_NONE;
      annunc_q <= 1'b1;
      kind_q   <= PH_FATAL;
    end else if (nf_end) begin
      code_q   <= nf_bad ? ERR_NONFATAL : ERR_NONE;
      msg_q    <= nf_bad ? MSG_PON_FAIL : MSG_READY;
      annunc_q <= nf_bad;
      kind_q   <= PH_NONFATAL;
    end else if (cmd_end) begin
      code_q   <= cmd_bad ? ERR_CMD : ERR_NONE;
      msg_q    <= cmd_bad ? MSG_TEST_FAIL : MSG_TEST_OK;
      annunc_q <= cmd_bad;
      kind_q   <= PH_CMD;
    end
  end

  // ==========================================================
  // register port
  wire logic [REG_AW-1:0] slot_off = reg_addr - REG_SLOT_BASE;
  wire logic slot_rd_hit = (reg_addr >= REG_SLOT_BASE) && (slot_off[1:0] == 2'b00) &&
                           (slot_off[REG_AW-1:2] < (REG_AW-2)'(NUM_SLOTS));
  wire logic [SLOT_AW-1:0] slot_rd_idx = slot_off[SLOT_AW+1:2];
  wire logic [CMD_W-1:0] last_word = (kind_q == PH_FATAL) ? CMD_W'(fatal_q) :
                                     (kind_q == PH_NONFATAL) ? CMD_W'(nf_q) : cmd_q;
  logic [7:0] hex_char;

  hex_digit_render u_hex (
    .word  (last_word),
    .digit (hex_sel_q),
    .ascii (hex_char)
  );

  always_comb begin
    status_w = '0;
    status_w[7:0] = state_q;
    status_w[STAT_READY]  = ready_q;
    status_w[STAT_LOCKED] = locked_q;
    status_w[STAT_PEND]   = cmd_pend_q;
    status_w[STAT_STUCK]  = stuck_q == CNT_W'(STUCK_CYC);
  end

  wire logic [31:0] error_string_query_w = {16'h0000, 2'b00, kind_q, 1'b0, msg_q, code_q};
  wire logic [31:0] rd_mux =
    (reg_addr == REG_STATUS)   ? status_w :
    (reg_addr == REG_FATAL)    ? 32'(fatal_q) :
    (reg_addr == REG_NONFATAL) ? 32'(nf_q) :
    (reg_addr == REG_CMDTEST)  ? cmd_q :
    (reg_addr == REG_ERROR_STRING_QUERY)   ? error_string_query_w :
    (reg_addr == REG_HEXSEL)   ? 32'(hex_sel_q) :
    (reg_addr == REG_HEXCHAR)  ? 32'(hex_char) :
    slot_rd_hit                ? 32'(slot_tab_q[slot_rd_idx]) : 32'h0000_0000;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_q   <= '0;
      hex_sel_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
      if (hexsel_wr) begin
        hex_sel_q <= reg_wdata[DIGIT_W-1:0];
      end
    end
  end

  assign reg_rdata    = rdata_q;
  assign check_phase  = phase_q;
  assign slot_poll    = poll_q;
  assign slot_sel     = slot_idx_q;
  assign error_code   = code_q;
  assign message      = msg_q;
  assign error_annunc = annunc_q;
  assign beep         = beep_q;
  assign tone         = tone_q;
  assign all_segments = seg_q;
  assign ready        = ready_q;
  assign locked       = locked_q;
  assign service_en   = serv_q;
  assign fatal_word   = fatal_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  fatal_bits_a: assert property ((fatal_word & ~FATAL_MASK) == '0)
    else $error("reserved fatal bit set");
  nf_order_a: assert property ($rose(state_q == ST_NONFATAL) |-> $past(fatal_ok))
    else $error("non-fatal test began without clean fatal test");
  nf_continue_a: assert property ((state_q == ST_NONFATAL && |nf_fail && !check_done)
    |=> state_q == ST_NONFATAL && (nf_q & $past(nf_fail)) == $past(nf_fail))
    else $error("non-fatal failure stopped the test");
  accum_keep_a: assert property ((state_q == ST_CMD && $past(state_q == ST_CMD))
    |-> (cmd_q & $past(cmd_q)) == $past(cmd_q))
    else $error("command word lost a bit");
  nf_report_a: assert property (nf_bad |=> error_code == ERR_NONFATAL && error_annunc
    && message == MSG_PON_FAIL && ready)
    else $error("non-fatal failure not reported");
  cmd_display_a: assert property ($rose(state_q == ST_CMD) |=> all_segments && tone)
    else $error("segments or tone off during command test");
  cmd_fail_a: assert property (cmd_bad |=> beep && error_code == ERR_CMD ##1 !beep)
    else $error("command failure not reported");
  cmd_pass_a: assert property ((cmd_end && !cmd_bad) |=> message == MSG_TEST_OK && !beep)
    else $error("pass message missing");
  clear_start_a: assert property ($rose(state_q == ST_CMD) |-> cmd_q == '0)
    else $error("command word not cleared at start");
  fatal_lock_a: assert property (fatal_bad |=> locked ##1 locked && error_code == ERR_FATAL)
    else $error("fatal failure did not lock");
  stuck_serv_a: assert property (stuck_now |=> !service_en)
    else $error("servicing while acknowledge stuck");
  table_freeze_a: assert property ((state_q != ST_ENUM_WAIT)
    |=> slot_tab_q[0] == $past(slot_tab_q[0]))
    else $error("slot table changed after enumeration");
  poll_wait_a: assert property ((state_q == ST_ENUM && ack_low) |=> !slot_poll)
    else $error("poll issued while acknowledge low");
endmodule
`default_nettype wire

// *** testbench/backplane_slots.sv ***
// plug-in module model answering slot polls on the shared acknowledge line
`timescale 1ns/1ps
`default_nettype none
module backplane_slots #(
  parameter int NUM_SLOTS = 4,
  parameter int SLOT_AW   = 2
) (
  // controller side
  input  wire logic                               sys_clk,
  input  wire logic                               slot_poll,
  input  wire logic [SLOT_AW-1:0]                 slot_sel,
  // bench controls
  input  wire logic                               stuck,
  input  wire logic [2*NUM_SLOTS-1:0]             kind_tab,
  // backplane lines
  output logic                                    transfer_acknowledge_n,
  output logic      [1:0]                         slot_resp,
  output logic      [self_test_pkg::MODEL_W-1:0]  slot_model
);
  import self_test_pkg::*;
  logic       ack_q;
  logic [4:0] wait_q;
  logic [1:0] kind;
  logic [7:0] model;
  assign kind  = kind_tab[2*slot_sel +: 2];
  assign model = 8'h40 + 8'(slot_sel);
  // ==========================================================
  // open line with pull-up: any module can hold it low
  assign transfer_acknowledge_n = ~(ack_q | stuck);
  // released data lines float; inverse keeps stale values from matching
  assign slot_resp  = ack_q ? kind : ~kind;
  assign slot_model = ack_q ? model : ~model;
  // higher slots answer slower; empty slots never answer
  always_ff @(posedge sys_clk) begin
    if (!slot_poll) begin
      ack_q  <= 1'b0;
      wait_q <= 5'h0;
    end else if (kind != SLOT_EMPTY && !ack_q) begin
      wait_q <= wait_q + 5'h1;
      ack_q  <= (wait_q == 5'(3 * slot_sel));
    end
  end
endmodule
`default_nettype wire

// *** testbench/self_test_error_collector_bench.sv ***
// self-checking bench of the self-test error collector
`timescale 1ns/1ps
`default_nettype none
module self_test_error_collector_bench;
  import self_test_pkg::*;
  // ==========================================================
  // signals
  logic        sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, check_done = 1'b0, stuck = 1'b0;
  logic [7:0]  reg_addr = 8'h0, error_code, slot_model, fatal_word;
  logic [31:0] reg_wdata = 32'h0, check_fail = 32'h0, reg_rdata;
  logic [1:0]  check_phase, slot_resp, slot_sel;
  logic        slot_poll, ack_n, error_annunc, beep, tone, all_segments, ready, locked, service_en;
  logic [2:0]  message;
  logic [7:0]  kind_tab = {SLOT_FULL, SLOT_EMPTY, SLOT_PARTIAL, SLOT_FULL};
  logic [15:0] lfsr_q = 16'h72ad;
  int          err_count = 0, total_checks = 0, beep_cnt = 0;

  self_test_error_collector #(.NUM_SLOTS(4), .SLOT_AW(2)) uut (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .check_phase(check_phase), .check_fail(check_fail),
    .check_done(check_done), .slot_poll(slot_poll), .slot_sel(slot_sel), .transfer_acknowledge_n(ack_n),
    .slot_resp(slot_resp), .slot_model(slot_model), .error_code(error_code), .message(message),
    .error_annunc(error_annunc), .beep(beep), .tone(tone), .all_segments(all_segments), .ready(ready),
    .locked(locked), .service_en(service_en), .fatal_word(fatal_word));
  backplane_slots #(.NUM_SLOTS(4), .SLOT_AW(2)) far_end (
    .sys_clk(sys_clk), .slot_poll(slot_poll), .slot_sel(slot_sel), .stuck(stuck), .kind_tab(kind_tab),
    .transfer_acknowledge_n(ack_n), .slot_resp(slot_resp), .slot_model(slot_model));

  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (beep === 1'b1) beep_cnt++;
  // whole run needs well under 10000 cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_count++;
    test_done();
  end
  // ==========================================================
  // helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic rnd32(output logic [31:0] v);
    lfsr_q = lfsr_next(lfsr_q);
    v[31:16] = lfsr_q;
    lfsr_q = lfsr_next(lfsr_q);
    v[15:0] = lfsr_q;
  endtask
  function automatic logic [31:0] slot_exp(input int i);
    logic [1:0] k;
    k = kind_tab[2*i +: 2];
    return (k == SLOT_EMPTY) ? 32'h0 : {22'h0, k, 8'h40 + 8'(i)};
  endfunction
  function automatic logic [7:0] hex_char(input logic [31:0] w, input int d);
    logic [3:0] n;
    n = w[4*d +: 4];
    return (n < 4'ha) ? ASCII_ZERO + 8'(n) : ASCII_A + 8'(n) - 8'ha;
  endfunction
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_check(input string name, input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check_val(name, exp, reg_rdata);
    @(posedge sys_clk);
  endtask
  task automatic wait_phase(input logic [1:0] p);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (check_phase !== p && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    check_val("check_phase", p, check_phase);
  endtask
  // fail flags over two cycles, the second beside done
  task automatic run_phase(input logic [1:0] p, input logic [31:0] f1, input logic [31:0] f2);
    wait_phase(p);
    if (p == PH_CMD) begin
      check_val("tone", 1, tone);
      check_val("segments", 1, all_segments);
    end
    @(posedge sys_clk);
    check_fail <= f1;
    @(posedge sys_clk);
    check_fail <= f2;
    check_done <= 1'b1;
    @(posedge sys_clk);
    check_fail <= 32'h0;
    check_done <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // sequence
  initial begin
    logic [31:0] f1, f2, nf, cw;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    reg_check("unmapped", 8'hfc, 32'h0);
    wait_phase(PH_FATAL);
    @(posedge sys_clk);
    check_val("slot_sel", 3, slot_sel);
    for (int i = 0; i < 4; i++) reg_check("slot", REG_SLOT_BASE + 8'(4 * i), slot_exp(i));
    run_phase(PH_FATAL, 32'hffffffc8, 32'h0);
    check_val("fatal_word", 0, fatal_word);
    rnd32(f1);
    rnd32(f2);
    f1[0] = 1'b1;
    f2[23] = 1'b1;
    nf = (f1 | f2) & NONFATAL_MASK;
    run_phase(PH_NONFATAL, f1, f2);
    check_val("error_code", ERR_NONFATAL, error_code);
    check_val("message", MSG_PON_FAIL, message);
    check_val("annunciator", 1, error_annunc);
    check_val("ready", 1, ready);
    reg_check("nonfatal", REG_NONFATAL, nf);
    reg_write(REG_NONFATAL, 32'h0);
    reg_check("nonfatal kept", REG_NONFATAL, nf);
    reg_check("error string", REG_ERROR_STRING_QUERY, {18'h0, PH_NONFATAL, 1'b0, MSG_PON_FAIL, ERR_NONFATAL});
    for (int d = 0; d < 8; d++) begin
      reg_write(REG_HEXSEL, 32'(d));
      reg_check("hex digit", REG_HEXCHAR, {24'h0, hex_char(nf, d)});
    end
    rnd32(f1);
    rnd32(f2);
    f1[3] = 1'b1;
    f2[25] = 1'b1;
    cw = (f1 | f2) & CMD_MASK;
    beep_cnt = 0;
    reg_write(REG_CTRL, 32'h1);
    run_phase(PH_CMD, f1, f2);
    check_val("beeps", 1, beep_cnt);
    check_val("error_code", ERR_CMD, error_code);
    check_val("message", MSG_TEST_FAIL, message);
    check_val("tone", 0, tone);
    reg_check("command word", REG_CMDTEST, cw);
    reg_check("nonfatal kept", REG_NONFATAL, nf);
    reg_write(REG_CTRL, 32'h1);
    run_phase(PH_CMD, 32'h0, 32'h0);
    check_val("message", MSG_TEST_OK, message);
    reg_check("command word", REG_CMDTEST, 32'h0);
    stuck <= 1'b1;
    repeat (STUCK_CYC + 100) @(posedge sys_clk);
    check_val("service", 0, service_en);
    check_val("message", MSG_TEST_OK, message);
    stuck <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check_val("service", 1, service_en);
    // a module plugged in late stays unseen until the next reset
    kind_tab <= {SLOT_FULL, SLOT_FULL, SLOT_PARTIAL, SLOT_FULL};
    @(posedge sys_clk);
    reg_check("slot late", REG_SLOT_BASE + 8'h8, 32'h0);
    reset <= 1'b1;
    stuck <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    // a line held low at power-on keeps the slot scan from starting
    repeat (20) @(posedge sys_clk);
    check_val("poll stalled", 0, slot_poll);
    reg_check("status", REG_STATUS, 32'h0000_0001);
    stuck <= 1'b0;
    rnd32(f1);
    f1[4] = 1'b1;
    beep_cnt = 0;
    run_phase(PH_FATAL, f1, 32'h0);
    reg_check("slot rebuilt", REG_SLOT_BASE + 8'h8, slot_exp(2));
    check_val("locked", 1, locked);
    check_val("error_code", ERR_FATAL, error_code);
    check_val("fatal_word", f1 & FATAL_MASK, fatal_word);
    check_val("beeps", 1, beep_cnt);
    reg_check("fatal reg", REG_FATAL, f1 & FATAL_MASK);
    test_done();
  end
endmodule
`default_nettype wire
